// ---- design/baf_regs.svh ----
// register offsets, field positions, opcodes and reset values of the byte datapath
`ifndef BAF_REGS_SVH
`define BAF_REGS_SVH

// register byte offsets on the register bus
`define BAF_OFS_INSTR    8'h00
`define BAF_OFS_ACC      8'h04
`define BAF_OFS_STATUS   8'h08
`define BAF_OFS_PTR      8'h0C
`define BAF_OFS_TMRCFG   8'h10
`define BAF_OFS_PRESC    8'h14
`define BAF_OFS_HIZ      8'h18
`define BAF_FILE_BASE    8'h80
`define BAF_FILE_MSB     7

// status field positions
`define BAF_ST_CARRY     0
`define BAF_ST_NIB       1
`define BAF_ST_ZERO      2

// opcode fields and encodings
`define BAF_OP_ADD       6'h07
`define BAF_OP_AND       6'h05
`define BAF_OP_JMP       3'h5
`define BAF_OP_HIZ       9'h000
`define BAF_DSEL_BIT     5
`define BAF_PTR_TOP      8

// special file addresses
`define BAF_F_TIMER      5'h01
`define BAF_F_PTR        5'h02
`define BAF_F_BANKA      5'h05
`define BAF_F_BANKB      5'h06
`define BAF_F_BANKC      5'h07

// reset values
`define BAF_RST_BYTE     8'h00
`define BAF_RST_PTR      9'h000
`define BAF_RST_HIZ      8'hFF
`define BAF_RST_FLAGS    3'h0

`endif

// ---- design/baf_pkg.sv ----
// types shared by the byte datapath modules
package baf_pkg;
    typedef logic [7:0] baf_byte_t;
    typedef logic [4:0] baf_fidx_t;
    typedef logic [8:0] baf_ptr_t;
endpackage : baf_pkg

// ---- design/baf_alu_if.sv ----
// carrier between the core and its arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface baf_alu_if;
    import baf_pkg::*;
    baf_byte_t acc;
    baf_byte_t opnd;
    logic      isAdd;
    baf_byte_t res;
    logic      carry;
    logic      nib;
    logic      zero;
    modport alu  (input acc, opnd, isAdd, output res, carry, nib, zero);
    modport core (output acc, opnd, isAdd, input res, carry, nib, zero);
endinterface : baf_alu_if
`default_nettype wire

// ---- design/baf_alu.sv ----
// add and and unit with flag generation
`timescale 1ns/1ps
`default_nettype none
`include "baf_regs.svh"
module baf_alu
    import baf_pkg::*;
(
    baf_alu_if.alu bus
);
    logic [8:0] sum;
    logic [4:0] low;

    // result and flags for both operations
    always_comb begin
        sum = {1'b0, bus.acc} + {1'b0, bus.opnd};
        low = {1'b0, bus.acc[3:0]} + {1'b0, bus.opnd[3:0]};
        if (bus.isAdd) begin
            bus.res = sum[7:0];                       // see RULE_06
        end else begin
            bus.res = bus.acc & bus.opnd;             // see RULE_07
        end
        bus.carry = sum[8];                           // see RULE_08
        bus.nib   = low[4];                           // see RULE_08
        bus.zero  = (bus.res == `BAF_RST_BYTE);       // see RULE_08
    end
endmodule : baf_alu
`default_nettype wire

// ---- design/baf_core.sv ----
// byte add and conjunction datapath with port, latch and timer side effects
//
// Summary of operation
// RULE_01 - pointer writes clear its ninth bit; absolute jump keeps its own ninth bit
// RULE_02 - port register read and written back uses synchronised pin levels
// RULE_03 - latch load with operand 5, 6, 7 copies accumulator to bank A, B, C
// RULE_04 - latch bit 1 tristates its pin; bit 0 enables the driver
// RULE_05 - writing timer count with destination 1 clears prescaler when assigned
// RULE_06 - add sums accumulator and file, routed by destination, flags C, nibble, Z
// RULE_07 - and combines accumulator and file, routed by destination, updates only Z
// RULE_08 - carry from bit 7, nibble carry from bit 3, zero on all-zero result
// RULE_09 - five-bit file field selects one of 32 file registers 0x00..0x1F
`timescale 1ns/1ps
`default_nettype none
`include "baf_regs.svh"
module baf_core
    import baf_pkg::*;
#(
    parameter int NFILE = 32
)(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // io banks a, b, c
    input  wire logic [23:0] bankPinIn,
    output var  logic [23:0] bankPinOut,
    output var  logic [23:0] bankPinOe
);
    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    baf_byte_t   file_ff [NFILE];
    baf_byte_t   acc_ff, nxt_acc;
    logic [2:0]  flags_ff, nxt_flags;
    baf_ptr_t    ptr_ff, nxt_ptr;
    logic        tmrAssign_ff, nxt_tmrAssign;
    baf_byte_t   presc_ff, nxt_presc;
    logic [23:0] hiz_ff, nxt_hiz;
    logic [23:0] oe_ff, nxt_oe;
    logic [23:0] pinMeta_ff, pinSync_ff;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic        fileWe;
    baf_fidx_t   fileWa;
    baf_byte_t   fileWd;

    baf_alu_if alu ();
    baf_alu u_alu (.bus(alu.alu));

    //------------------------------------------------------------
    // decode
    //------------------------------------------------------------
    logic        access, commit, isFile, hit, exec;
    logic [11:0] op;
    baf_fidx_t   fIdx, aIdx;
    logic        dSel, isAdd, isAnd, isJmp, isHiz, isPort;
    logic [1:0]  bank, hizBank;
    baf_byte_t   fileRd, opnd;
    logic [31:0] rdVal;

    // bus phase and opcode field extraction
    always_comb begin
        access  = psel && penable;
        commit  = access && pready_ff;
        isFile  = paddr[`BAF_FILE_MSB];
        aIdx    = paddr[6:2];
        exec    = commit && pwrite && (paddr == `BAF_OFS_INSTR);
        op      = pwdata[11:0];
        fIdx    = op[4:0];                                         // see RULE_09
        dSel    = op[`BAF_DSEL_BIT];
        isAdd   = (op[11:6] == `BAF_OP_ADD);
        isAnd   = (op[11:6] == `BAF_OP_AND);
        isJmp   = (op[11:9] == `BAF_OP_JMP);
        isHiz   = (op[11:3] == `BAF_OP_HIZ) && (op[2:0] >= 3'(`BAF_F_BANKA));
        hizBank = 2'(op[2:0] - 3'(`BAF_F_BANKA));                  // see RULE_03
        isPort  = (fIdx >= `BAF_F_BANKA) && (fIdx <= `BAF_F_BANKC);
        bank    = 2'(fIdx - `BAF_F_BANKA);
        fileRd  = (fIdx == `BAF_F_PTR) ? ptr_ff[7:0] : file_ff[fIdx];
        // port written back to itself takes its operand from the pins
        opnd    = (isPort && dSel) ? pinSync_ff[bank*8 +: 8] : fileRd; // see RULE_02
        alu.acc   = acc_ff;
        alu.opnd  = opnd;
        alu.isAdd = isAdd;
    end

    // register read mux and unmapped detection
    always_comb begin
        rdVal = 32'h0000_0000;
        hit   = 1'b1;
        if (isFile) begin
            rdVal = {24'h00_0000, file_ff[aIdx]};
        end else begin
            case (paddr)
                `BAF_OFS_INSTR:  rdVal = 32'h0000_0000;
                `BAF_OFS_ACC:    rdVal = {24'h00_0000, acc_ff};
                `BAF_OFS_STATUS: rdVal = {29'h0000_0000, flags_ff};
                `BAF_OFS_PTR:    rdVal = {23'h00_0000, ptr_ff};
                `BAF_OFS_TMRCFG: rdVal = {31'h0000_0000, tmrAssign_ff};
                `BAF_OFS_PRESC:  rdVal = {24'h00_0000, presc_ff};
                `BAF_OFS_HIZ:    rdVal = {8'h00, hiz_ff};
                default:         hit = 1'b0;
            endcase
        end
    end

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    always_comb begin
        nxt_acc       = acc_ff;
        nxt_flags     = flags_ff;
        nxt_ptr       = ptr_ff;
        nxt_tmrAssign = tmrAssign_ff;
        nxt_presc     = presc_ff + 8'h01;   // free-running prescaler
        nxt_hiz       = hiz_ff;
        fileWe        = 1'b0;
        fileWa        = fIdx;
        fileWd        = alu.res;
        nxt_pready    = access && !pready_ff;
        nxt_pslverr   = access && !pready_ff && !hit;
        nxt_prdata    = (access && !pready_ff && !pwrite) ? rdVal : 32'h0000_0000;
        // software writes to plain registers
        if (commit && pwrite && hit) begin
            if (isFile) begin
                fileWe = 1'b1;
                fileWa = aIdx;
                fileWd = pwdata[7:0];
            end else begin
                case (paddr)
                    `BAF_OFS_ACC:    nxt_acc = pwdata[7:0];
                    `BAF_OFS_STATUS: nxt_flags = pwdata[2:0];
                    `BAF_OFS_TMRCFG: nxt_tmrAssign = pwdata[0];
                    `BAF_OFS_HIZ:    nxt_hiz = pwdata[23:0];
                    default:         nxt_acc = acc_ff;
                endcase
            end
        end
        // instruction execution, one cycle
        if (exec && (isAdd || isAnd)) begin
            nxt_flags[`BAF_ST_ZERO] = alu.zero;                     // see RULE_07
            if (isAdd) begin
                nxt_flags[`BAF_ST_CARRY] = alu.carry;               // see RULE_06
                nxt_flags[`BAF_ST_NIB]   = alu.nib;                 // see RULE_08
            end
            if (!dSel) begin
                nxt_acc = alu.res;                                  // see RULE_06
            end else if (fIdx == `BAF_F_PTR) begin
                nxt_ptr = {1'b0, alu.res};                          // see RULE_01
            end else begin
                fileWe = 1'b1;                                      // see RULE_09
                if ((fIdx == `BAF_F_TIMER) && tmrAssign_ff) begin
                    nxt_presc = `BAF_RST_BYTE;                      // see RULE_05
                end
            end
        end else if (exec && isJmp) begin
            nxt_ptr = op[8:0];                                      // see RULE_01
        end else if (exec && isHiz) begin
            nxt_hiz[hizBank*8 +: 8] = acc_ff;                       // see RULE_03
        end
        nxt_oe = ~nxt_hiz;                                          // see RULE_04
    end

    // registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff       <= `BAF_RST_BYTE;
            flags_ff     <= `BAF_RST_FLAGS;
            ptr_ff       <= `BAF_RST_PTR;
            tmrAssign_ff <= 1'b0;
            presc_ff     <= `BAF_RST_BYTE;
            hiz_ff       <= {3{`BAF_RST_HIZ}};
            oe_ff        <= ~{3{`BAF_RST_HIZ}};
            prdata_ff    <= 32'h0000_0000;
            pready_ff    <= 1'b0;
            pslverr_ff   <= 1'b0;
        end else begin
            acc_ff       <= nxt_acc;
            flags_ff     <= nxt_flags;
            ptr_ff       <= nxt_ptr;
            tmrAssign_ff <= nxt_tmrAssign;
            presc_ff     <= nxt_presc;
            hiz_ff       <= nxt_hiz;
            oe_ff        <= nxt_oe;
            prdata_ff    <= nxt_prdata;
            pready_ff    <= nxt_pready;
            pslverr_ff   <= nxt_pslverr;
        end
    end

    // file array, one block per entry, and the shared two-stage pin synchroniser
    for (genvar i = 0; i < NFILE; i++) begin : g_file
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                file_ff[i] <= `BAF_RST_BYTE;
            end else if (fileWe && (fileWa == 5'(i))) begin
                file_ff[i] <= fileWd;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_ff <= 24'h00_0000;
            pinSync_ff <= 24'h00_0000;
        end else begin
            pinMeta_ff <= bankPinIn;
            pinSync_ff <= pinMeta_ff;
        end
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign bankPinOut = {file_ff[`BAF_F_BANKC], file_ff[`BAF_F_BANKB], file_ff[`BAF_F_BANKA]};
    assign bankPinOe  = oe_ff;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ptr_top_clear: assert property ( // see RULE_01
        exec && (isAdd || isAnd) && dSel && fIdx == `BAF_F_PTR
        |=> ptr_ff[`BAF_PTR_TOP] == 1'b0) else $error("pointer top bit not cleared");
    a_jump_keep_top: assert property ( // see RULE_01
        exec && isJmp |=> ptr_ff == $past(pwdata[8:0])) else $error("jump target wrong");
    a_rmw_pin_value: assert property ( // see RULE_02
        exec && (isAdd || isAnd) && dSel && isPort
        |=> file_ff[$past(fIdx)] == $past(isAdd ? 8'(acc_ff + pinSync_ff[bank*8 +: 8])
        : (acc_ff & pinSync_ff[bank*8 +: 8]))) else $error("port write-back not from pins");
    a_hiz_bank_load: assert property ( // see RULE_03
        exec && isHiz |=> hiz_ff[$past(hizBank)*8 +: 8] == $past(acc_ff))
        else $error("latch load wrong");
    a_oe_from_hiz: assert property ( // see RULE_04
        ##1 bankPinOe == ~hiz_ff) else $error("driver enable not inverse of latch");
    a_presc_cleared: assert property ( // see RULE_05
        exec && (isAdd || isAnd) && dSel && fIdx == `BAF_F_TIMER && tmrAssign_ff
        |=> presc_ff == `BAF_RST_BYTE) else $error("prescaler not cleared");
    a_add_to_acc: assert property ( // see RULE_06
        exec && isAdd && !dSel |=> acc_ff == 8'($past(acc_ff) + $past(opnd))
        && flags_ff[`BAF_ST_CARRY] == $past((9'(acc_ff) + 9'(opnd)) > 9'h0FF))
        else $error("add to accumulator wrong");
    a_and_flags: assert property ( // see RULE_07
        exec && isAnd |=> flags_ff[1:0] == $past(flags_ff[1:0])
        && flags_ff[`BAF_ST_ZERO] == ($past(acc_ff & opnd) == 8'h00))
        else $error("and flags wrong");
    a_nib_carry: assert property ( // see RULE_08
        exec && isAdd
        |=> flags_ff[`BAF_ST_NIB] == $past((5'(acc_ff[3:0]) + 5'(opnd[3:0])) > 5'h0F))
        else $error("nibble carry wrong");
    a_file_select: assert property ( // see RULE_09
        exec && isAnd && dSel && !isPort && fIdx != `BAF_F_PTR
        |=> file_ff[$past(fIdx)] == $past(acc_ff & opnd)) else $error("file write wrong");

    c_add_file:  cover property (exec && isAdd && dSel);
    c_and_acc:   cover property (exec && isAnd && !dSel);
    c_hiz_load:  cover property (exec && isHiz);
    c_jump:      cover property (exec && isJmp);
endmodule : baf_core
`default_nettype wire

// ---- test/byte_add_and_file_ops_tb.sv ----
// self-checking bench for the byte add and conjunction datapath
`timescale 1ns/1ps
`default_nettype none
`include "baf_regs.svh"
module byte_add_and_file_ops_tb
    import baf_pkg::*;
;
    // ------------------------------------------------------------
    // signals, instance and clock
    // ------------------------------------------------------------
    typedef struct packed {
        logic       isAdd;
        logic       dSel;
        baf_fidx_t  fIdx;
        baf_byte_t  accIn;
        baf_byte_t  fileIn;
        logic [2:0] preSt;
        baf_byte_t  expRes;
        logic [2:0] expSt;
    } baf_row_t;
    localparam int NROW = 7;
    baf_row_t    rows [NROW];
    logic        sys_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [23:0] bankPinIn;
    logic [23:0] bankPinOut;
    logic [23:0] bankPinOe;
    logic [31:0] rdv;
    logic        lastErr;
    int          fails = 0;
    int          samples_checked = 0;

    baf_core #(.NFILE(32)) i_baf_core (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bankPinIn(bankPinIn),
        .bankPinOut(bankPinOut), .bankPinOe(bankPinOe)
    );

    // free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // bus, compare and closing tasks
    // ------------------------------------------------------------
    // one apb transfer, entered just after a rising edge
    task automatic apbXfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge sys_clk);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hung wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdv     = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apbXfer

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apbXfer(1'b1, addr, data);
    endtask : wr

    task automatic rd(input logic [7:0] addr);
        apbXfer(1'b0, addr, 32'h00000000);
    endtask : rd

    function automatic logic [7:0] fileAddr(input baf_fidx_t f);
        return `BAF_FILE_BASE + {1'b0, f, 2'b00};
    endfunction : fileAddr

    // issue one byte operation through the instruction register
    task automatic runOp(input logic isAdd, input logic d, input baf_fidx_t f);
        wr(`BAF_OFS_INSTR, {20'h00000, (isAdd ? `BAF_OP_ADD : `BAF_OP_AND), d, f});
    endtask : runOp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    // watchdog against a hung handshake
    initial begin
        #50000;
        fails++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk   = 1'b0;
        rst_n     = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h00000000;
        bankPinIn = 24'h000000;
        // add/and, d, f, acc, file, preset status, result, status after
        rows = '{
            '{1'b1, 1'b0, 5'h08, 8'h17, 8'hC2, 3'h0, 8'hD9, 3'h0},
            '{1'b1, 1'b1, 5'h1F, 8'hFF, 8'h01, 3'h0, 8'h00, 3'h7},
            '{1'b1, 1'b0, 5'h0A, 8'h08, 8'h08, 3'h0, 8'h10, 3'h2},
            '{1'b1, 1'b1, 5'h11, 8'h80, 8'h80, 3'h0, 8'h00, 3'h5},
            '{1'b0, 1'b1, 5'h0C, 8'h17, 8'hC2, 3'h3, 8'h02, 3'h3},
            '{1'b0, 1'b0, 5'h00, 8'hF0, 8'h0F, 3'h3, 8'h00, 3'h7},
            '{1'b1, 1'b1, 5'h03, 8'h01, 8'h01, 3'h7, 8'h02, 3'h0}
        };
        repeat (6) @(posedge sys_clk);
        chk({8'h00, bankPinOe}, 32'h00000000);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(`BAF_OFS_HIZ);
        chk(rdv, 32'h00FFFFFF);
        // ordinary add and conjunction cases
        foreach (rows[i]) begin
            wr(`BAF_OFS_ACC, {24'h000000, rows[i].accIn});
            wr(fileAddr(rows[i].fIdx), {24'h000000, rows[i].fileIn});
            wr(`BAF_OFS_STATUS, {29'h00000000, rows[i].preSt});
            runOp(rows[i].isAdd, rows[i].dSel, rows[i].fIdx);
            rd(`BAF_OFS_ACC);
            chk(rdv, {24'h000000, rows[i].dSel ? rows[i].accIn : rows[i].expRes});
            rd(fileAddr(rows[i].fIdx));
            chk(rdv, {24'h000000, rows[i].dSel ? rows[i].expRes : rows[i].fileIn});
            rd(`BAF_OFS_STATUS);
            chk(rdv, {29'h00000000, rows[i].expSt});
        end
        // jump keeps the ninth pointer bit, a byte write clears it
        wr(`BAF_OFS_INSTR, {20'h00000, `BAF_OP_JMP, 9'h1FF});
        rd(`BAF_OFS_PTR);
        chk(rdv, 32'h000001FF);
        wr(`BAF_OFS_ACC, 32'h00000002);
        runOp(1'b1, 1'b1, `BAF_F_PTR);
        rd(`BAF_OFS_PTR);
        chk(rdv, 32'h00000001);
        // latch loads for banks a, b, c and the driver enables
        wr(`BAF_OFS_ACC, 32'h0000003C);
        wr(`BAF_OFS_INSTR, 32'h00000005);
        wr(`BAF_OFS_ACC, 32'h000000A5);
        wr(`BAF_OFS_INSTR, 32'h00000006);
        wr(`BAF_OFS_ACC, 32'h0000000F);
        wr(`BAF_OFS_INSTR, 32'h00000007);
        rd(`BAF_OFS_HIZ);
        chk(rdv, 32'h000FA53C);
        chk({8'h00, bankPinOe}, 32'h00F05AC3);
        // write-back on a port takes the pin levels, not the latch
        bankPinIn <= 24'h00000F;
        wr(fileAddr(`BAF_F_BANKA), 32'h000000FF);
        wr(`BAF_OFS_ACC, 32'h000000FF);
        runOp(1'b0, 1'b1, `BAF_F_BANKA);
        rd(fileAddr(`BAF_F_BANKA));
        chk(rdv, 32'h0000000F);
        chk({24'h000000, bankPinOut[7:0]}, 32'h0000000F);
        bankPinIn <= 24'h0000F0;
        runOp(1'b0, 1'b0, `BAF_F_BANKA);
        rd(`BAF_OFS_ACC);
        chk(rdv, 32'h0000000F);
        // timer write with destination one clears the assigned prescaler
        wr(`BAF_OFS_TMRCFG, 32'h00000001);
        runOp(1'b1, 1'b1, `BAF_F_TIMER);
        // cleared at the commit edge, then one count per edge up to the read
        rd(`BAF_OFS_PRESC);
        chk(rdv, 32'h00000002);
        // destination zero leaves the prescaler running
        runOp(1'b1, 1'b0, `BAF_F_TIMER);
        rd(`BAF_OFS_PRESC);
        chk(rdv, 32'h0000000A);
        // unmapped offset is refused
        wr(8'h1C, 32'h000000AA);
        chk({31'h00000000, lastErr}, 32'h00000001);
        rd(8'h1C);
        chk(rdv, 32'h00000000);
        chk({31'h00000000, lastErr}, 32'h00000001);
        // second reset in mid-run: drivers off, latches back to tristate
        rst_n <= 1'b0;
        @(posedge sys_clk);
        chk({bankPinOut, 8'h00}, 32'h00000000);
        chk({8'h00, bankPinOe}, 32'h00000000);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(`BAF_OFS_HIZ);
        chk(rdv, 32'h00FFFFFF);
        rd(`BAF_OFS_ACC);
        chk(rdv, 32'h00000000);
        print_verdict();
    end
endmodule : byte_add_and_file_ops_tb
`default_nettype wire
